// ==== hdl/spi_dec_pkg.sv ====
// How it works
// RQ1: host clock at most 80/50 MHz
// RQ2: whole bytes, MSB first, opcode leads
// RQ3: unknown opcode ignored until deselect
// RQ4: array reads: addresses, dummy per opcode
// RQ5: page writes: three address bytes, data
// RQ6: erases: address except whole-chip erase
// RQ7: identification page opcodes decoded with address
// RQ8: sleep enter/exit carry no bytes
// RQ9: latch set opcode sets write latch
// RQ10: latch clear opcode clears write latch
// RQ11: latch set only at exact eighth bit
// RQ12: latch clear only at exact eighth bit
// RQ13: status byte shifted out MSB first
// RQ14: status read accepted during busy cycle
// RQ15: status byte repeats until deselect
// RQ16: config then safety byte, alternating
// RQ17: safety cleared when select rises
// RQ18: safety clear only at exact eighth bit
// RQ19: volatile byte repeats, accepted while busy
// RQ20: status write: one/two bytes, more discarded
// RQ21: volatile write needs write latch set
// RQ22: status write refused while cycle busy
// RQ23: deselect ends reads, releases output, restarts
package spi_dec_pkg;

  typedef logic [7:0]  byte_type;
  typedef logic [11:0] bits_type;

  typedef struct packed {
    logic       known;
    logic [1:0] addr_bytes;
    logic       dummy;
  } op_info_type;

  localparam byte_type OP_LATCH_SET      = 8'h06;
  localparam byte_type OP_LATCH_CLEAR    = 8'h04;
  localparam byte_type OP_STATUS_READ    = 8'h05;
  localparam byte_type OP_STATUS_WRITE   = 8'h01;
  localparam byte_type OP_ARRAY_READ     = 8'h03;
  localparam byte_type OP_FAST_SINGLE    = 8'h0b;
  localparam byte_type OP_FAST_DUAL      = 8'h3b;
  localparam byte_type OP_FAST_QUAD      = 8'h6b;
  localparam byte_type OP_PAGE_ERASE_PRG = 8'h02;
  localparam byte_type OP_PAGE_PROGRAM   = 8'h0a;
  localparam byte_type OP_PAGE_ERASE     = 8'hdb;
  localparam byte_type OP_SECTOR_ERASE   = 8'h20;
  localparam byte_type OP_BLOCK_ERASE    = 8'hd8;
  localparam byte_type OP_FULL_ERASE     = 8'hc7;
  localparam byte_type OP_IDENT_READ     = 8'h83;
  localparam byte_type OP_IDENT_FAST     = 8'h8b;
  localparam byte_type OP_IDENT_WRITE    = 8'h82;
  localparam byte_type OP_SLEEP_ENTER    = 8'hb9;
  localparam byte_type OP_SLEEP_EXIT     = 8'hab;
  localparam byte_type OP_CFG_SAFE_READ  = 8'h15;
  localparam byte_type OP_SAFETY_CLEAR   = 8'h50;
  localparam byte_type OP_VOL_READ       = 8'h85;
  localparam byte_type OP_VOL_WRITE      = 8'h81;

  // bit counts at which a deselect completes an instruction, then the counter's saturation and wrap values
  localparam bits_type BITS_OPCODE    = 12'h008;
  localparam bits_type BITS_ONE_DATA  = 12'h010;
  localparam bits_type BITS_TWO_DATA  = 12'h018;
  localparam bits_type BITS_SAT       = 12'hfff;
  localparam bits_type BITS_SAT_WRAP  = 12'hff8;

  localparam int       ST_WIP_BIT     = 0;
  localparam int       ST_LATCH_BIT   = 1;
  localparam int       ST_WR_LSB      = 2;
  localparam int       VOL_BUFLD_BIT  = 0;
  localparam int       VOL_BUFFER_LOAD_ENABLE_BIT  = 1;
  localparam byte_type STATUS_RST     = 8'h00;
  localparam byte_type CONFIG_RST     = 8'h20;
  localparam byte_type SAFETY_RST     = 8'h00;

  localparam int SYS_CLK_MHZ       = 100;
  localparam int SCLK_MAX_MHZ      = 80;
  localparam int SCLK_SLOW_MAX_MHZ = 50;
  localparam int HOST_DIV_HALF     = 4;

  function automatic op_info_type op_info(input byte_type op);
    op_info_type r;
    r = '{known: 1'b1, addr_bytes: 2'd0, dummy: 1'b0};
    case (op)
      OP_ARRAY_READ, OP_PAGE_ERASE_PRG, OP_PAGE_PROGRAM,
      OP_PAGE_ERASE, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
      OP_IDENT_READ, OP_IDENT_WRITE:                     r.addr_bytes = 2'd3;
      OP_FAST_SINGLE, OP_FAST_DUAL, OP_FAST_QUAD,
      OP_IDENT_FAST:                                     r = '{known: 1'b1, addr_bytes: 2'd3, dummy: 1'b1};
      OP_LATCH_SET, OP_LATCH_CLEAR, OP_STATUS_READ, OP_STATUS_WRITE,
      OP_FULL_ERASE, OP_SLEEP_ENTER, OP_SLEEP_EXIT, OP_CFG_SAFE_READ,
      OP_SAFETY_CLEAR, OP_VOL_READ, OP_VOL_WRITE:        r.addr_bytes = 2'd0;
      default:                                           r.known = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ==== hdl/spi_link_if.sv ====
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_d;
  logic miso_oe_n;
  logic miso;

  // released line reads high, as with a pull-up
  assign miso = miso_oe_n ? 1'b1 : miso_d;

  modport dev  (input sclk, input cs_n, input mosi, output miso_d, output miso_oe_n);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ==== hdl/bit_sync.sv ====
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule

// ==== hdl/spi_dev_end.sv ====
module spi_dev_end (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  spi_link_if.dev                   LINK,
  input  wire logic                 CYCLE_BUSY,
  input  wire spi_dec_pkg::byte_type SAFETY_SET,
  input  wire logic                 BUF_FULL,
  output logic                      CMD_VALID,
  output spi_dec_pkg::byte_type     CMD_OPCODE,
  output logic [1:0]                CMD_ADDR_BYTES,
  output logic                      CMD_DUMMY,
  output spi_dec_pkg::bits_type     CMD_BITS,
  output logic                      WRITE_LATCH,
  output spi_dec_pkg::byte_type     STATUS,
  output spi_dec_pkg::byte_type     CONFIG,
  output spi_dec_pkg::byte_type     SAFETY,
  output spi_dec_pkg::byte_type     VOLATILE
);
  import spi_dec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link side, posedge: input latch

  logic        link_rst_q;
  logic        fresh_q;
  logic        tag_q;
  bits_type    bits_q;
  bits_type    cnt;
  byte_type    shift_q;
  byte_type    sh;
  byte_type    opcode_q;
  byte_type    byte1_q;
  byte_type    byte2_q;

  assign cnt = fresh_q ? '0 : bits_q;
  assign sh  = {shift_q[6:0], LINK.mosi};

  // fresh marks a new frame; counter itself keeps its value for the sys side
  always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      fresh_q <= 1'b1;                                  // [RQ23]
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // toggles once per clocked frame so a clockless select pulse is not replayed
  always_ff @(posedge LINK.sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      tag_q <= 1'b0;
    end else if (fresh_q) begin
      tag_q <= ~tag_q;
    end
  end

  always_ff @(posedge LINK.sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      bits_q <= '0;
    end else if (cnt == BITS_SAT) begin
      bits_q <= BITS_SAT_WRAP;                          // keeps byte rhythm on endless reads
    end else begin
      bits_q <= cnt + 12'h001;
    end
  end

  always_ff @(posedge LINK.sclk) begin
    shift_q <= sh;                                      // [RQ2]
    if (cnt == BITS_OPCODE - 12'h001) begin
      opcode_q <= sh;
    end
    if (cnt == BITS_ONE_DATA - 12'h001) begin
      byte1_q <= sh;
    end
    if (cnt == BITS_TWO_DATA - 12'h001) begin
      byte2_q <= sh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side, negedge: output drive

  byte_type    status_q;
  byte_type    config_q;
  byte_type    safety_q;
  byte_type    vol_q;
  logic [31:0] regs_s;
  byte_type    out_q;
  logic        oe_n_q;
  logic        alt_q;
  logic        load;
  byte_type    load_byte;

  // register bytes only change at deselect or slowly with busy, SAFETY_SET and BUF_FULL; per-bit sync is enough
  bit_sync #(.W(32)) u_reg_sync (
    .clk (LINK.sclk),
    .d   ({status_q, config_q, safety_q, vol_q}),
    .q   (regs_s)
  );

  always_comb begin
    load      = 1'b0;
    load_byte = '0;
    if (bits_q >= BITS_OPCODE && bits_q[2:0] == 3'd0) begin
      unique case (opcode_q)
        OP_STATUS_READ: begin                            // [RQ13] [RQ14] [RQ15]
          load      = 1'b1;
          load_byte = regs_s[31:24];
        end
        OP_CFG_SAFE_READ: begin                          // [RQ16]
          load      = 1'b1;
          load_byte = alt_q ? regs_s[15:8] : regs_s[23:16];
        end
        OP_VOL_READ: begin                               // [RQ19]
          load      = 1'b1;
          load_byte = regs_s[7:0];
        end
        default: begin
          load      = 1'b0;                              // [RQ3]
          load_byte = '0;
        end
      endcase
    end
  end

  always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      out_q  <= '0;                                     // [RQ23]
      oe_n_q <= 1'b1;
      alt_q  <= 1'b0;
    end else if (load) begin
      out_q  <= load_byte;
      oe_n_q <= 1'b0;
      alt_q  <= ~alt_q;
    end else begin
      out_q  <= {out_q[6:0], 1'b0};
    end
  end

  assign LINK.miso_d    = out_q[7];
  assign LINK.miso_oe_n = oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // system side: deselect detection

  logic [1:0]  link_s;
  logic        cs_prev_q;
  logic        seen_q;
  logic        done;
  op_info_type info;

  bit_sync #(.W(2)) u_cs_sync (
    .clk (SYS_CLK),
    .d   ({LINK.cs_n, tag_q}),
    .q   (link_s)
  );

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      link_rst_q <= 1'b1;
      cs_prev_q  <= 1'b1;
      seen_q     <= 1'b0;
    end else begin
      link_rst_q <= 1'b0;
      cs_prev_q  <= link_s[1];
      if (link_s[1] && !cs_prev_q) begin
        seen_q <= link_s[0];
      end
    end
  end

  // link words are frozen: the clock stands once select is high
  assign done = link_s[1] && !cs_prev_q && (link_s[0] != seen_q);
  assign info = op_info(opcode_q);

  ////////////////////////////////////////////////////////////////////////////
  // system side: register execution

  logic       latch_q;
  logic [5:0] stat_hi_q;
  logic       buffer_load_enable_q;
  logic       exact8;
  logic       wr_ok;

  assign exact8 = (bits_q == BITS_OPCODE);
  assign wr_ok  = latch_q && !CYCLE_BUSY;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      latch_q <= STATUS_RST[ST_LATCH_BIT];
    end else if (done && exact8 && opcode_q == OP_LATCH_SET) begin
      latch_q <= 1'b1;                                  // [RQ9] [RQ11]
    end else if (done && exact8 && opcode_q == OP_LATCH_CLEAR) begin
      latch_q <= 1'b0;                                  // [RQ10] [RQ12]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stat_hi_q <= STATUS_RST[7:ST_WR_LSB];
      config_q  <= CONFIG_RST;
    end else if (done && opcode_q == OP_STATUS_WRITE && wr_ok) begin // [RQ22]
      if (bits_q == BITS_ONE_DATA) begin                // [RQ20]
        stat_hi_q <= byte1_q[7:ST_WR_LSB];
      end else if (bits_q == BITS_TWO_DATA) begin
        stat_hi_q <= byte1_q[7:ST_WR_LSB];
        config_q  <= byte2_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      safety_q <= SAFETY_RST;
    end else if (done && exact8 && opcode_q == OP_SAFETY_CLEAR) begin
      safety_q <= SAFETY_SET;                           // [RQ17] [RQ18]
    end else begin
      safety_q <= safety_q | SAFETY_SET;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      buffer_load_enable_q <= 1'b0;
    end else if (done && opcode_q == OP_VOL_WRITE && latch_q && bits_q == BITS_ONE_DATA) begin
      buffer_load_enable_q <= byte1_q[VOL_BUFFER_LOAD_ENABLE_BIT];                // [RQ21]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      status_q <= STATUS_RST;
      vol_q    <= '0;
    end else begin
      status_q <= {stat_hi_q, latch_q, CYCLE_BUSY};
      vol_q    <= {6'h00, buffer_load_enable_q, !buffer_load_enable_q || BUF_FULL};
    end
  end

  // decode report for the array engine
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      CMD_VALID      <= 1'b0;
      CMD_OPCODE     <= '0;
      CMD_ADDR_BYTES <= '0;
      CMD_DUMMY      <= 1'b0;
      CMD_BITS       <= '0;
    end else begin
      CMD_VALID <= done && info.known && bits_q >= BITS_OPCODE; // [RQ3]
      if (done) begin
        CMD_OPCODE     <= opcode_q;                     // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8]
        CMD_ADDR_BYTES <= info.addr_bytes;
        CMD_DUMMY      <= info.dummy;
        CMD_BITS       <= bits_q;
      end
    end
  end

  assign WRITE_LATCH = latch_q;
  assign STATUS      = status_q;
  assign CONFIG      = config_q;
  assign SAFETY      = safety_q;
  assign VOLATILE    = vol_q;
endmodule

// ==== hdl/spi_host_end.sv ====
module spi_host_end #(
  parameter int DIV_HALF = spi_dec_pkg::HOST_DIV_HALF
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  spi_link_if.host                   LINK,
  input  wire logic                  REQ_VALID,
  output logic                       REQ_READY,
  input  wire spi_dec_pkg::byte_type REQ_OPCODE,
  input  wire logic [2:0]            REQ_NBYTES,
  input  wire logic [31:0]           REQ_WDATA,
  output spi_dec_pkg::byte_type      RX_DATA,
  output logic                       RX_VALID
);
  import spi_dec_pkg::*;

  // slowest documented limit covers every opcode
  if (SYS_CLK_MHZ > 2 * DIV_HALF * SCLK_SLOW_MAX_MHZ || DIV_HALF < 3) begin : g_chk // [RQ1]
    $error("DIV_HALF too small for the link clock limit");
  end

  localparam int DW = $clog2(2 * DIV_HALF + 1);

  typedef enum {H_IDLE, H_LEAD, H_SHIFT, H_TRAIL} hstate_type;

  hstate_type    state_q;
  logic [DW-1:0] div_q;
  logic [2:0]    bit_q;
  logic [2:0]    byte_q;
  logic [2:0]    nbytes_q;
  logic [39:0]   tx_q;
  byte_type      rx_q;
  logic          miso_s;
  logic          tick;

  bit_sync #(.W(1)) u_miso_sync (
    .clk (SYS_CLK),
    .d   (LINK.miso),
    .q   (miso_s)
  );

  assign tick = (div_q == DW'(DIV_HALF - 1));

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q   <= H_IDLE;
      div_q     <= '0;
      bit_q     <= '0;
      byte_q    <= '0;
      nbytes_q  <= '0;
      tx_q      <= '0;
      rx_q      <= '0;
      REQ_READY <= 1'b0;
      RX_DATA   <= '0;
      RX_VALID  <= 1'b0;
      LINK.sclk <= 1'b0;
      LINK.cs_n <= 1'b1;
      LINK.mosi <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            tx_q      <= {REQ_OPCODE, REQ_WDATA};
            nbytes_q  <= REQ_NBYTES;
            LINK.mosi <= REQ_OPCODE[7];                 // [RQ2]
            LINK.cs_n <= 1'b0;
            div_q     <= '0;
            bit_q     <= '0;
            byte_q    <= '0;
            state_q   <= H_LEAD;
          end
        end
        H_LEAD: begin
          div_q <= div_q + DW'(1);
          if (tick) begin
            div_q   <= '0;
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_q <= div_q + DW'(1);
          if (tick) begin
            div_q     <= '0;
            LINK.sclk <= !LINK.sclk;
            if (!LINK.sclk) begin
              rx_q <= {rx_q[6:0], miso_s};
            end else begin
              bit_q     <= bit_q + 3'd1;
              tx_q      <= {tx_q[38:0], 1'b0};
              LINK.mosi <= tx_q[38];
              if (bit_q == 3'd7) begin
                if (byte_q != 3'd0) begin
                  RX_DATA  <= rx_q;
                  RX_VALID <= 1'b1;
                end
                // deselect only on a byte boundary
                if (byte_q == nbytes_q) begin            // [RQ11] [RQ12] [RQ18] [RQ20]
                  state_q <= H_TRAIL;
                end else begin
                  byte_q <= byte_q + 3'd1;
                end
              end
            end
          end
        end
        H_TRAIL: begin
          div_q <= div_q + DW'(1);
          if (tick) begin
            LINK.cs_n <= 1'b1;
          end
          if (div_q == DW'(2 * DIV_HALF - 1)) begin
            div_q   <= '0;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ==== sim/spi_link_assertions.sv ====
module spi_link_assertions
  import spi_dec_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_d,
  input wire logic miso_oe_n,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0]  cnt_q;
  byte_type    op_q;
  logic [15:0] hist_q;
  logic [7:0]  rise_q;
  logic        sclk_q;
  logic        rd;

  assign rd = (op_q == 8'h05) || (op_q == 8'h15) || (op_q == 8'h85);

  // link-side view, cleared by deselect just as the device is
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      op_q <= 8'h00;
    end else if (cnt_q < 5'h08) begin
      op_q <= {op_q[6:0], mosi};
    end
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      hist_q <= 16'h0000;
    end else begin
      hist_q <= {hist_q[14:0], miso};
    end
  end
  always_ff @(posedge SYS_CLK) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || cs_n) begin
      rise_q <= 8'h00;
    end else if (sclk && !sclk_q) begin
      rise_q <= rise_q + 8'h01;
    end
  end

  ////////////////////////////////////////
  sequence s_deselect;
    $rose(cs_n);
  endsequence
  sequence s_gap;
    cs_n [*3];
  endsequence
  property p_bytes;
    @(posedge SYS_CLK) disable iff (!RST_N) s_deselect |-> rise_q[2:0] == 3'h0 && rise_q != 8'h00;
  endproperty
  a_bytes: assert property (p_bytes) else $error("frame not whole bytes");
  property p_gap;
    @(posedge SYS_CLK) disable iff (!RST_N) s_deselect |-> s_gap;
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
  property p_release;
    @(posedge SYS_CLK) disable iff (!RST_N) cs_n |-> miso_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");
  property p_slow;
    @(posedge SYS_CLK) disable iff (!RST_N) $rose(sclk) |=> sclk;
  endproperty
  a_slow: assert property (p_slow) else $error("link clock too fast");
  property p_setup;
    @(posedge SYS_CLK) disable iff (!RST_N) $rose(sclk) |-> $stable(mosi);
  endproperty
  a_setup: assert property (p_setup) else $error("data moved at clock rise");
  property p_drive;
    @(posedge sclk) disable iff (cs_n) cnt_q >= 5'h08 && rd |-> !miso_oe_n && miso == miso_d;
  endproperty
  a_drive: assert property (p_drive) else $error("read byte not driven");
  property p_quiet;
    @(posedge sclk) disable iff (cs_n) cnt_q >= 5'h08 && !rd |-> miso_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output driven without read");
  property p_rep8;
    @(posedge sclk) disable iff (cs_n) cnt_q >= 5'h10 && (op_q == 8'h05 || op_q == 8'h85) |-> miso == hist_q[7];
  endproperty
  a_rep8: assert property (p_rep8) else $error("register byte not repeated");
  property p_rep16;
    @(posedge sclk) disable iff (cs_n) cnt_q >= 5'h18 && op_q == 8'h15 |-> miso == hist_q[15];
  endproperty
  a_rep16: assert property (p_rep16) else $error("byte pair not alternating");
endmodule

// ==== sim/tb_spi_eeprom_instruction_decoder.sv ====
module tb_spi_eeprom_instruction_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_dec_pkg::*;

  logic        sys_clk;
  logic        rst_n;
  logic        busy;
  logic        buf_full;
  byte_type    sset;
  logic        req_valid;
  logic        req_ready;
  byte_type    req_op;
  logic [2:0]  req_n;
  logic [31:0] req_wd;
  byte_type    rx_data;
  logic        rx_valid;
  logic        cmd_valid;
  byte_type    cmd_op;
  logic [1:0]  cmd_addr;
  logic        cmd_dummy;
  bits_type    cmd_bits;
  logic        latch;
  logic        latch_b;
  byte_type    status;
  byte_type    cfg;
  byte_type    safety;
  byte_type    vol;
  byte_type    rx [4];
  int          nrx;
  int          n0;
  int          cv_n        = 0;
  int          fail_count  = 0;
  int          checks_done = 0;
  byte_type    ops [15]    = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'h02, 8'h0a, 8'hdb, 8'h20, 8'hd8, 8'hc7, 8'h83, 8'h8b,
                               8'h82, 8'hb9, 8'hab};
  logic [2:0]  dec [15]    = '{3'h6, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h0, 3'h6, 3'h7, 3'h6, 3'h0, 3'h0};

  spi_link_if lnk ();
  spi_link_if lnk_b ();

  spi_host_end i_spi_host_end (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(lnk), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_OPCODE(req_op), .REQ_NBYTES(req_n), .REQ_WDATA(req_wd), .RX_DATA(rx_data),
    .RX_VALID(rx_valid));
  spi_dev_end i_spi_dev_end (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(lnk), .CYCLE_BUSY(busy), .SAFETY_SET(sset),
    .BUF_FULL(buf_full), .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_op), .CMD_ADDR_BYTES(cmd_addr), .CMD_DUMMY(cmd_dummy),
    .CMD_BITS(cmd_bits), .WRITE_LATCH(latch), .STATUS(status), .CONFIG(cfg), .SAFETY(safety), .VOLATILE(vol));
  // second device faces the bench driver that cuts frames off-byte
  spi_dev_end i_spi_dev_end_b (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(lnk_b), .CYCLE_BUSY(busy), .SAFETY_SET(sset),
    .BUF_FULL(buf_full), .CMD_VALID(), .CMD_OPCODE(), .CMD_ADDR_BYTES(), .CMD_DUMMY(), .CMD_BITS(),
    .WRITE_LATCH(latch_b), .STATUS(), .CONFIG(), .SAFETY(), .VOLATILE());
  spi_link_assertions i_spi_link_assertions (.SYS_CLK(sys_clk), .RST_N(rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .mosi(lnk.mosi), .miso_d(lnk.miso_d), .miso_oe_n(lnk.miso_oe_n), .miso(lnk.miso));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) begin
      cv_n <= cv_n + 1;
    end
  end

  ////////////////////////////////////////
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic send(input byte_type op, input logic [2:0] n, input logic [31:0] wd);
    int g;
    g = 0;
    while (req_ready !== 1'b1 && g < 3000) begin
      tick;
      g++;
    end
    req_valid = 1'b1;
    req_op = op;
    req_n = n;
    req_wd = wd;
    tick;
    req_valid = 1'b0;
    nrx = 0;
    do begin
      tick;
      g++;
      if (rx_valid === 1'b1 && nrx < 4) begin
        rx[nrx] = rx_data;
        nrx++;
      end
    end while (req_ready !== 1'b1 && g < 3000);
    chk("send done", g < 3000, 1'b1);
    // let the synced deselect reach the register side
    repeat (6) tick;
  endtask

  task automatic rdc(input string nm, input int n, input logic [31:0] e);
    chk(nm, nrx, n);
    for (int i = 0; i < n; i++) begin
      chk(nm, rx[i], e[31 - 8 * i -: 8]);
    end
  endtask

  // raw frame on the second link, clock only while selected
  task automatic frame_b(input logic [15:0] v, input int n);
    lnk_b.cs_n = 1'b0;
    #6;
    for (int i = 0; i < n; i++) begin
      lnk_b.mosi = v[15 - i];
      #6;
      lnk_b.sclk = 1'b1;
      #6;
      lnk_b.sclk = 1'b0;
    end
    #6;
    lnk_b.cs_n = 1'b1;
    lnk_b.mosi = ~lnk_b.mosi;
    repeat (8) tick;
  endtask

  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    finish_test;
  end

  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    busy = 1'b0;
    buf_full = 1'b0;
    sset = 8'h00;
    req_valid = 1'b0;
    req_op = 8'h00;
    req_n = 3'h0;
    req_wd = 32'h00000000;
    lnk_b.cs_n = 1'b0;
    lnk_b.sclk = 1'b0;
    lnk_b.mosi = 1'b0;
    repeat (2) @(posedge sys_clk);
    // a real select rise marks the second device's first frame as fresh
    #1;
    lnk_b.cs_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) tick;
    chk("status rst", status, 8'h00);
    chk("config rst", cfg, 8'h20);
    chk("safety rst", safety, 8'h00);
    chk("vol rst", vol, 8'h01);
    busy = 1'b1;
    repeat (4) tick;
    send(8'h05, 3'h3, 32'h0);
    rdc("busy status", 3, 32'h01010100);
    send(8'h85, 3'h2, 32'h0);
    rdc("busy vol", 2, 32'h01010000);
    busy = 1'b0;
    send(8'h06, 3'h0, 32'h0);
    chk("latch set", latch, 1'b1);
    send(8'h05, 3'h2, 32'h0);
    rdc("status", 2, 32'h02020000);
    send(8'h04, 3'h1, 32'h0);
    chk("clear long", latch, 1'b1);
    send(8'h04, 3'h0, 32'h0);
    chk("latch clear", latch, 1'b0);
    send(8'h06, 3'h1, 32'h0);
    chk("set long", latch, 1'b0);
    sset = 8'ha5;
    tick;
    sset = 8'h00;
    repeat (4) tick;
    send(8'h15, 3'h4, 32'h0);
    rdc("cfg safety", 4, 32'h20a520a5);
    send(8'h50, 3'h1, 32'h0);
    chk("sclear long", safety, 8'ha5);
    send(8'h50, 3'h0, 32'h0);
    chk("sclear", safety, 8'h00);
    send(8'h06, 3'h0, 32'h0);
    busy = 1'b1;
    repeat (4) tick;
    send(8'h01, 3'h1, 32'hfc000000);
    chk("wr busy", status, 8'h03);
    busy = 1'b0;
    send(8'h01, 3'h1, 32'h3c000000);
    chk("wr one", status, 8'h3e);
    send(8'h01, 3'h2, 32'h00400000);
    chk("wr two", status, 8'h02);
    chk("wr two cfg", cfg, 8'h40);
    send(8'h01, 3'h3, 32'hfcffff00);
    chk("wr three", status, 8'h02);
    chk("wr three cfg", cfg, 8'h40);
    send(8'h81, 3'h1, 32'h02000000);
    chk("vol wr", vol, 8'h02);
    buf_full = 1'b1;
    repeat (4) tick;
    send(8'h85, 3'h2, 32'h0);
    rdc("vol rd", 2, 32'h03030000);
    send(8'h04, 3'h0, 32'h0);
    send(8'h81, 3'h1, 32'h00000000);
    chk("vol locked", vol, 8'h03);
    n0 = cv_n;
    send(8'h77, 3'h2, 32'h06000000);
    rdc("unknown", 2, 32'hffff0000);
    chk("unknown latch", latch, 1'b0);
    chk("unknown cmd", cv_n - n0, 0);
    for (int i = 0; i < 15; i++) begin
      n0 = cv_n;
      send(ops[i], 3'h4, 32'h0);
      chk("opcode", cmd_op, ops[i]);
      chk("decode", {cmd_addr, cmd_dummy}, dec[i]);
      chk("bits", cmd_bits, 12'h028);
      chk("cmd pulse", cv_n - n0, 1);
    end
    frame_b(16'h0600, 8);
    chk("b set", latch_b, 1'b1);
    frame_b(16'h0400, 9);
    chk("b clear 9", latch_b, 1'b1);
    frame_b(16'h0400, 7);
    chk("b clear 7", latch_b, 1'b1);
    frame_b(16'h0400, 8);
    chk("b clear", latch_b, 1'b0);
    frame_b(16'h0600, 15);
    chk("b set 15", latch_b, 1'b0);
    finish_test;
  end
endmodule
